// [hdmc_assertions.sv]
`timescale 1ns/1ns
`include "hdmc_defines.vh"
// ******
// display mode checker
// ******
module hdmc_assertions (
  input wire       pclk,             // clock
  input wire       presetn,          // async reset, active low
  input wire [2:0] display_mode,     // applied mode
  input wire       xy_mode,          // x-y deflection
  input wire       skew_trim,        // trim active
  input wire       show_main,        // main trace drawn
  input wire       show_delayed,     // delayed trace drawn
  input wire [4:0] delayed_run_step, // delayed speed step
  input wire       var_on_delayed,   // variable on delayed
  input wire       intensify,        // brighten now
  input wire       zone_ref,         // reference zone
  input wire       zone_delta,       // delta zone
  input wire       dv_cancel         // cancel pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a mode held for two cycles implies its outputs
  property p_mode(m, c);
    display_mode == m && $past(display_mode) == m |-> c;
  endproperty

  chk_xy_horiz:
  assert property (p_mode(`HDMC_M_XY, xy_mode)) else $error("xy flag low in xy mode");
  chk_locked_main:
  assert property (p_mode(`HDMC_M_MAIN, show_main && !show_delayed && !var_on_delayed))
    else $error("locked mode shows delayed");
  chk_inten_hidden:
  assert property (p_mode(`HDMC_M_INTEN, !show_delayed && var_on_delayed))
    else $error("intensified mode shows delayed");
  chk_delayed_only:
  assert property (p_mode(`HDMC_M_DEL, !show_main && show_delayed))
    else $error("delayed-only mode shows main");
  chk_trim_flag:
  assert property (p_mode(`HDMC_M_TRIM, skew_trim)) else $error("trim flag low");
  chk_run_range:
  assert property (delayed_run_step <= `HDMC_FAST_STEP) else $error("run step beyond 5 ns");
  chk_dv_pulse:
  assert property ($rose(dv_cancel) |=> !dv_cancel) else $error("cancel pulse too long");
  chk_zone_bright:
  assert property ($rose(intensify) |-> zone_ref || zone_delta) else $error("bright without zone");

  cover property (display_mode == `HDMC_M_ALT);
  cover property ($rose(dv_cancel));
  cover property ($rose(zone_delta));
  cover property ($rose(skew_trim));
endmodule

// [hdmc_defines.vh]
// What this block does
// - 25 main speeds, 0.5 s to 5 ns
// - main fully ccw selects X-Y mode
// - 22 delayed speeds, 50 ms to 5 ns
// - equal speeds, knob in: main only
// - knob out brightens main during delayed sweep
// - equal speeds intensified: delayed hidden, 100x clamped
// - delayed never slower than main
// - zone start equals reference knob delay
// - time measurement free-run: reference and delta zones
// - triggered: zones start at trigger after delay
// - alternate vertical: reference first, delta second
// - chop or multi-trigger: both zones everywhere
// - pulling knob cancels voltage measurement
// - pushing knob in at equal speeds clears voltage warning
// - main 5 ns, knob out: skew trim
// - knob out, delayed faster: alternate sweeps
// - knob in, delayed faster: delayed only
// - variable control: main when locked or in X-Y, else delayed
// - variable stretches scale up to threefold
// - variable fine then coarse, reversal fine
`ifndef HDMC_DEFINES_VH
`define HDMC_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define HDMC_PANEL      12'h000
`define HDMC_MEAS       12'h004
`define HDMC_REF_DLY    12'h008
`define HDMC_DELTA_DLY  12'h00C
`define HDMC_ZONE_LEN   12'h010
`define HDMC_STATUS     12'h014
`define HDMC_SCALE      12'h018

// ****************************************
// field positions
// ****************************************
`define HDMC_F_PULLED   16
`define HDMC_F_TRIGAFT  17
`define HDMC_F_CHOP     18
`define HDMC_F_MULTI    19
`define HDMC_F_DV       0
`define HDMC_F_DT       1
`define HDMC_F_RECIP    2
`define HDMC_F_WARN     8

// ****************************************
// reset values and speed steps
// ****************************************
`define HDMC_ZLEN_RST   16'h0010
`define HDMC_MAIN_RST   5'h01
`define HDMC_FAST_STEP  5'h18
`define HDMC_DEL_OFS    5'h03
`define HDMC_DEL_MAX    5'h15
`define HDMC_X100_STEPS 5'h06
`define HDMC_FINE_RUN   5'h10
`define HDMC_COARSE_INC 8'h08

// ****************************************
// display modes
// ****************************************
`define HDMC_M_MAIN     3'h0
`define HDMC_M_INTEN    3'h1
`define HDMC_M_ALT      3'h2
`define HDMC_M_DEL      3'h3
`define HDMC_M_XY       3'h4
`define HDMC_M_TRIM     3'h5

`endif

// [hdmc_panel_model.sv]
`timescale 1ns/1ns
// ******
// knobs and sweep circuitry
// ******
module hdmc_panel_model (
  input  wire  pclk,             // clock
  output logic main_sweep_start, // sweep begins
  output logic main_sweep_end,   // sweep ends
  output logic delayed_trig,     // trigger event
  output logic var_cw,           // variable step cw
  output logic var_ccw           // variable step ccw
);
  // idle levels
  initial begin
    {main_sweep_start, main_sweep_end, delayed_trig, var_cw, var_ccw} = 5'h0;
  end

  // one sweep of len clocks, trigger at clock trig (0 none)
  task sweep(input int len, input int trig);
    @(posedge pclk) main_sweep_start <= 1'b1;
    @(posedge pclk) main_sweep_start <= 1'b0;
    for (int i = 1; i <= len; i++) begin
      @(posedge pclk);
      delayed_trig <= (i == trig);
    end
    main_sweep_end <= 1'b1;
    @(posedge pclk) main_sweep_end <= 1'b0;
    delayed_trig <= 1'b0;
  endtask

  // n detent steps in one direction
  task turn(input bit ccw, input int n);
    repeat (n) begin
      @(posedge pclk);
      var_ccw <= ccw;
      var_cw <= !ccw;
      @(posedge pclk);
      var_ccw <= 1'b0;
      var_cw <= 1'b0;
    end
  endtask
endmodule

// [hdmc_speed_rom.v]
`timescale 1ns/1ns
module hdmc_speed_rom (
  input  wire        pclk,    // clock
  input  wire [4:0]  step,    // speed step, 0 slowest
  output reg  [31:0] ns_div   // calibrated ns per division
);

  // ****************************************
  // 1-2-5 speed table, registered read
  // ****************************************
  always @(posedge pclk) begin
    case (step)
      5'h00: ns_div <= 32'h1DCD_6500;
      5'h01: ns_div <= 32'h0BEB_C200;
      5'h02: ns_div <= 32'h05F5_E100;
      5'h03: ns_div <= 32'h02FA_F080;
      5'h04: ns_div <= 32'h0131_2D00;
      5'h05: ns_div <= 32'h0098_9680;
      5'h06: ns_div <= 32'h004C_4B40;
      5'h07: ns_div <= 32'h001E_8480;
      5'h08: ns_div <= 32'h000F_4240;
      5'h09: ns_div <= 32'h0007_A120;
      5'h0A: ns_div <= 32'h0003_0D40;
      5'h0B: ns_div <= 32'h0001_86A0;
      5'h0C: ns_div <= 32'h0000_C350;
      5'h0D: ns_div <= 32'h0000_4E20;
      5'h0E: ns_div <= 32'h0000_2710;
      5'h0F: ns_div <= 32'h0000_1388;
      5'h10: ns_div <= 32'h0000_07D0;
      5'h11: ns_div <= 32'h0000_03E8;
      5'h12: ns_div <= 32'h0000_01F4;
      5'h13: ns_div <= 32'h0000_00C8;
      5'h14: ns_div <= 32'h0000_0064;
      5'h15: ns_div <= 32'h0000_0032;
      5'h16: ns_div <= 32'h0000_0014;
      5'h17: ns_div <= 32'h0000_000A;
      default: ns_div <= 32'h0000_0005;
    endcase
  end

endmodule

// [hdmc_top.v]
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
`include "hdmc_defines.vh"
module hdmc_top (
  input  wire        pclk,              // 25 MHz clock
  input  wire        presetn,           // async reset, active low
  input  wire        psel,              // apb select
  input  wire        penable,           // apb access phase
  input  wire        pwrite,            // apb write
  input  wire [11:0] paddr,             // apb byte address
  input  wire [31:0] pwdata,            // apb write data
  output reg  [31:0] prdata,            // apb read data
  output wire        pready,            // apb ready
  output wire        pslverr,           // apb error, unmapped
  input  wire        main_sweep_start,  // main sweep begins, pulse
  input  wire        main_sweep_end,    // main sweep ends, pulse
  input  wire        delayed_trig,      // delayed trigger event, pulse
  input  wire        var_cw,            // variable knob step cw, pulse
  input  wire        var_ccw,           // variable knob step ccw, pulse
  input  wire [2:0]  trace_ord,         // ordinal of trace being drawn
  input  wire [2:0]  trace_count,       // number of selected traces
  output reg  [2:0]  display_mode,      // applied display mode
  output reg         xy_mode,           // channel 1 drives horizontal
  output reg         skew_trim,         // channel 2 skew trim active
  output reg         show_main,         // main sweep trace drawn
  output reg         show_delayed,      // delayed sweep trace drawn
  output reg  [4:0]  delayed_run_step,  // speed step the delayed sweep runs
  output reg         var_on_delayed,    // variable acts on delayed sweep
  output reg         intensify,         // brighten main trace now
  output reg         zone_ref,          // reference zone active
  output reg         zone_delta,        // delta zone active
  output reg         dv_cancel          // voltage measurement cancelled, pulse
);

  // ****************************************
  // helper functions
  // ****************************************
  function [4:0] main_step_of;
    input [4:0] sel;
    begin
      if (sel == 5'h00)
        main_step_of = 5'h00;
      else if (sel > `HDMC_FAST_STEP)
        main_step_of = `HDMC_FAST_STEP;
      else
        main_step_of = sel - 5'h01;
    end
  endfunction

  function [4:0] del_step_of;
    input [4:0] sel;
    begin
      if (sel > `HDMC_DEL_MAX)
        del_step_of = `HDMC_FAST_STEP;
      else
        del_step_of = sel + `HDMC_DEL_OFS;
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg  [4:0]  main_sel;
  reg  [4:0]  delayed_sel;
  reg         pulled;
  reg         trig_after_delay;
  reg         chop;
  reg         multi_trig;
  reg         dv_on;
  reg         dt_on;
  reg         recip_on;
  reg         warn;
  reg  [15:0] ref_dly;
  reg  [15:0] delta_dly;
  reg  [15:0] zone_len;
  reg  [7:0]  var_value;
  reg  [4:0]  var_run;
  reg         var_dir;
  reg         pulled_q;
  reg         alt_phase;
  reg         sweeping;
  reg         zone_hit;
  reg  [15:0] sweep_cnt;
  reg  [1:0]  zon;
  reg  [1:0]  zdone;
  reg  [15:0] zcnt0;
  reg  [15:0] zcnt1;
  reg  [31:0] scale_ns;
  reg  [2:0]  next_mode;
  reg  [4:0]  next_run;
  reg  [4:0]  rom_step;
  reg  [4:0]  wr_main;
  reg  [4:0]  wr_del;
  reg  [31:0] rd_mux;
  reg         rd_ok;
  wire [31:0] cal_ns;
  wire [39:0] stretch;
  wire [4:0]  m_step;
  wire [4:0]  d_step;
  wire        wr_acc;
  wire        measuring;
  wire        both_zones;
  wire        delta_wanted;
  wire        ref_wanted;
  wire        locked;

  assign m_step    = main_step_of(main_sel);
  assign d_step    = del_step_of(delayed_sel);
  assign wr_acc    = psel & penable & pwrite;
  assign measuring = dt_on | recip_on;
  assign locked    = ~pulled & (d_step == m_step);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~rd_ok;

  // ****************************************
  // mode decode from panel state
  // ****************************************
  always @* begin
    next_run = d_step;
    if (main_sel == 5'h00) begin
      next_mode = `HDMC_M_XY;
    end else if (pulled && m_step == `HDMC_FAST_STEP) begin
      next_mode = `HDMC_M_TRIM;
    end else if (pulled && d_step > m_step) begin
      next_mode = `HDMC_M_ALT;
    end else if (pulled) begin
      next_mode = `HDMC_M_INTEN;
      if (m_step + `HDMC_X100_STEPS > `HDMC_FAST_STEP)
        next_run = `HDMC_FAST_STEP;
      else
        next_run = m_step + `HDMC_X100_STEPS;
    end else if (d_step > m_step) begin
      next_mode = `HDMC_M_DEL;
    end else begin
      next_mode = `HDMC_M_MAIN;
    end
  end

  // ****************************************
  // interlock on panel writes
  // ****************************************
  always @* begin
    wr_main = pwdata[4:0];
    wr_del  = pwdata[12:8];
    if (del_step_of(wr_del) < main_step_of(wr_main)) begin
      if (main_step_of(wr_main) < `HDMC_DEL_OFS)
        wr_del = 5'h00;
      else
        wr_del = main_step_of(wr_main) - `HDMC_DEL_OFS;
    end
  end

  // ****************************************
  // register read decode
  // ****************************************
  always @* begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `HDMC_PANEL: begin
        rd_mux[4:0]   = main_sel;
        rd_mux[12:8]  = delayed_sel;
        rd_mux[`HDMC_F_PULLED]  = pulled;
        rd_mux[`HDMC_F_TRIGAFT] = trig_after_delay;
        rd_mux[`HDMC_F_CHOP]    = chop;
        rd_mux[`HDMC_F_MULTI]   = multi_trig;
      end
      `HDMC_MEAS: begin
        rd_mux[`HDMC_F_DV]    = dv_on;
        rd_mux[`HDMC_F_DT]    = dt_on;
        rd_mux[`HDMC_F_RECIP] = recip_on;
        rd_mux[`HDMC_F_WARN]  = warn;
      end
      `HDMC_REF_DLY:   rd_mux[15:0] = ref_dly;
      `HDMC_DELTA_DLY: rd_mux[15:0] = delta_dly;
      `HDMC_ZONE_LEN:  rd_mux[15:0] = zone_len;
      `HDMC_STATUS: begin
        rd_mux[2:0]  = display_mode;
        rd_mux[7:3]  = delayed_run_step;
        rd_mux[15:8] = var_value;
        rd_mux[16]   = (var_run >= `HDMC_FINE_RUN);
        rd_mux[17]   = alt_phase;
      end
      `HDMC_SCALE: rd_mux = scale_ns;
      default: rd_ok = 1'b0;
    endcase
  end

  // ****************************************
  // apb slave, read data latched in setup
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata           <= 32'h0000_0000;
      main_sel         <= `HDMC_MAIN_RST;
      delayed_sel      <= 5'h00;
      pulled           <= 1'b0;
      trig_after_delay <= 1'b0;
      chop             <= 1'b0;
      multi_trig       <= 1'b0;
      ref_dly          <= 16'h0000;
      delta_dly        <= 16'h0000;
      zone_len         <= `HDMC_ZLEN_RST;
    end else begin
      if (psel && !penable)
        prdata <= rd_mux;
      if (wr_acc && paddr == `HDMC_PANEL) begin
        main_sel         <= wr_main;
        delayed_sel      <= wr_del;
        pulled           <= pwdata[`HDMC_F_PULLED];
        trig_after_delay <= pwdata[`HDMC_F_TRIGAFT];
        chop             <= pwdata[`HDMC_F_CHOP];
        multi_trig       <= pwdata[`HDMC_F_MULTI];
      end
      if (wr_acc && paddr == `HDMC_REF_DLY)
        ref_dly <= pwdata[15:0];
      if (wr_acc && paddr == `HDMC_DELTA_DLY)
        delta_dly <= pwdata[15:0];
      if (wr_acc && paddr == `HDMC_ZONE_LEN)
        zone_len <= pwdata[15:0];
    end
  end

  // ****************************************
  // measurement flags, cancel and warning
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dv_on     <= 1'b0;
      dt_on     <= 1'b0;
      recip_on  <= 1'b0;
      warn      <= 1'b0;
      pulled_q  <= 1'b0;
      dv_cancel <= 1'b0;
    end else begin
      pulled_q  <= pulled;
      dv_cancel <= 1'b0;
      if (pulled && !pulled_q && dv_on) begin
        dv_on     <= 1'b0;
        dv_cancel <= 1'b1;
      end
      if (!pulled && pulled_q && locked)
        warn <= 1'b0;
      if (wr_acc && paddr == `HDMC_MEAS) begin
        dt_on    <= pwdata[`HDMC_F_DT];
        recip_on <= pwdata[`HDMC_F_RECIP];
        if (pwdata[`HDMC_F_DV] && !locked) begin
          dv_on <= 1'b0;
          warn  <= 1'b1;
        end else begin
          dv_on <= pwdata[`HDMC_F_DV];
        end
      end
    end
  end

  // ****************************************
  // applied mode, taken at sweep start, X-Y taken at once
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_mode     <= `HDMC_M_MAIN;
      delayed_run_step <= 5'h00;
      xy_mode          <= 1'b0;
      skew_trim        <= 1'b0;
      var_on_delayed   <= 1'b0;
    end else if (main_sweep_start || next_mode == `HDMC_M_XY) begin
      display_mode     <= next_mode;
      delayed_run_step <= next_run;
      xy_mode          <= (next_mode == `HDMC_M_XY);
      skew_trim        <= (next_mode == `HDMC_M_TRIM);
      var_on_delayed   <= (next_mode != `HDMC_M_MAIN) &&
                          (next_mode != `HDMC_M_XY);
    end
  end

  // ****************************************
  // sweep timer and intensified zones
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sweeping  <= 1'b0;
      sweep_cnt <= 16'h0000;
      zon       <= 2'b00;
      zdone     <= 2'b00;
      zcnt0     <= 16'h0000;
      zcnt1     <= 16'h0000;
      zone_hit  <= 1'b0;
    end else if (main_sweep_start) begin
      sweeping  <= 1'b1;
      sweep_cnt <= 16'h0000;
      zon       <= 2'b00;
      zdone     <= 2'b00;
      zone_hit  <= 1'b0;
    end else if (main_sweep_end) begin
      sweeping <= 1'b0;
      zon      <= 2'b00;
    end else if (sweeping) begin
      sweep_cnt <= sweep_cnt + 16'h0001;
      // reference zone
      if (zon[0]) begin
        zcnt0 <= zcnt0 + 16'h0001;
        if (zcnt0 + 16'h0001 >= zone_len) begin
          zon[0]   <= 1'b0;
          zdone[0] <= 1'b1;
        end
      end else if (!zdone[0] && sweep_cnt >= ref_dly &&
                   (!trig_after_delay || delayed_trig)) begin
        zon[0]   <= 1'b1;
        zcnt0    <= 16'h0000;
        zone_hit <= 1'b1;
      end
      // delta zone, only while a time measurement runs
      if (zon[1]) begin
        zcnt1 <= zcnt1 + 16'h0001;
        if (zcnt1 + 16'h0001 >= zone_len) begin
          zon[1]   <= 1'b0;
          zdone[1] <= 1'b1;
        end
      end else if (measuring && !zdone[1] && sweep_cnt >= delta_dly &&
                   (!trig_after_delay || delayed_trig)) begin
        zon[1]   <= 1'b1;
        zcnt1    <= 16'h0000;
        zone_hit <= 1'b1;
      end
    end
  end

  // ****************************************
  // zone placement on traces
  // ****************************************
  assign both_zones   = chop | multi_trig | (trace_count <= 3'h1);
  assign delta_wanted = measuring & (both_zones | trace_ord != 3'h0);
  assign ref_wanted   = ~measuring | both_zones | (trace_ord != 3'h1);

  // ****************************************
  // alternate phase and display outputs
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_phase    <= 1'b0;
      show_main    <= 1'b1;
      show_delayed <= 1'b0;
      intensify    <= 1'b0;
      zone_ref     <= 1'b0;
      zone_delta   <= 1'b0;
    end else begin
      if (main_sweep_end) begin
        if (display_mode != `HDMC_M_ALT || alt_phase)
          alt_phase <= 1'b0;
        else if (!trig_after_delay || zone_hit)
          alt_phase <= 1'b1;
      end
      zone_ref   <= zon[0] & ref_wanted;
      zone_delta <= zon[1] & delta_wanted;
      case (display_mode)
        `HDMC_M_MAIN: begin
          show_main    <= 1'b1;
          show_delayed <= 1'b0;
          intensify    <= 1'b0;
        end
        `HDMC_M_INTEN, `HDMC_M_TRIM: begin
          show_main    <= 1'b1;
          show_delayed <= 1'b0;
          intensify    <= (zon[0] & ref_wanted) | (zon[1] & delta_wanted);
        end
        `HDMC_M_ALT: begin
          show_main    <= ~alt_phase;
          show_delayed <= alt_phase;
          intensify    <= ~alt_phase & ((zon[0] & ref_wanted) | (zon[1] & delta_wanted));
        end
        `HDMC_M_DEL: begin
          show_main    <= 1'b0;
          show_delayed <= 1'b1;
          intensify    <= 1'b0;
        end
        default: begin
          show_main    <= 1'b0;
          show_delayed <= 1'b0;
          intensify    <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // variable speed knob, fine then coarse
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      var_value <= 8'h00;
      var_run   <= 5'h00;
      var_dir   <= 1'b0;
    end else if (var_cw ^ var_ccw) begin
      if (var_ccw != var_dir)
        var_run <= 5'h00;
      else if (var_run < `HDMC_FINE_RUN)
        var_run <= var_run + 5'h01;
      var_dir <= var_ccw;
      if (var_ccw) begin
        if (var_run >= `HDMC_FINE_RUN && var_ccw == var_dir)
          var_value <= (var_value > 8'hF7) ? 8'hFF : var_value + `HDMC_COARSE_INC;
        else if (var_value != 8'hFF)
          var_value <= var_value + 8'h01;
      end else begin
        if (var_run >= `HDMC_FINE_RUN && var_ccw == var_dir)
          var_value <= (var_value < `HDMC_COARSE_INC) ? 8'h00 :
                       var_value - `HDMC_COARSE_INC;
        else if (var_value != 8'h00)
          var_value <= var_value - 8'h01;
      end
    end
  end

  // ****************************************
  // readout scale: calibrated speed stretched by variable
  // ****************************************
  always @* begin
    rom_step = var_on_delayed ? delayed_run_step : m_step;
  end

  hdmc_speed_rom u_rom (
    .pclk   (pclk),
    .step   (rom_step),
    .ns_div (cal_ns)
  );

  assign stretch = {8'h00, cal_ns} * {32'h0000_0000, var_value};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      scale_ns <= 32'h0000_0000;
    else
      scale_ns <= cal_ns + stretch[38:7];
  end

endmodule

// [hdmc_top_test.sv]
`timescale 1ns/1ns
`include "hdmc_defines.vh"
module hdmc_top_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, p;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        main_sweep_start, main_sweep_end, delayed_trig, var_cw, var_ccw;
  logic [2:0]  trace_ord, trace_count, display_mode, e;
  logic        xy_mode, skew_trim, show_main, show_delayed, var_on_delayed;
  logic        intensify, zone_ref, zone_delta, dv_cancel;
  logic [4:0]  delayed_run_step, m, d;
  logic [43:0] corners;
  int          failures, checked, nr, nd, ni, hit;

  hdmc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .main_sweep_start, .main_sweep_end, .delayed_trig, .var_cw,
    .var_ccw, .trace_ord, .trace_count, .display_mode, .xy_mode, .skew_trim, .show_main,
    .show_delayed, .delayed_run_step, .var_on_delayed, .intensify, .zone_ref,
    .zone_delta, .dv_cancel);
  hdmc_panel_model u_pm (.pclk, .main_sweep_start, .main_sweep_end, .delayed_trig,
    .var_cw, .var_ccw);

  // ******
  // clock and watchdog
  // ******
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    finish_test();
  end

  task finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task chk(input logic [32:0] g, input logic [32:0] x);
    checked++;
    if (g !== x) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask

  // one apb transfer, waits for pready
  task apb(input bit w, input logic [11:0] a, input logic [31:0] dw);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dw;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      failures++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task set_panel(input logic [4:0] sm, input logic [4:0] sd, input logic sp, input logic st);
    apb(1, `HDMC_PANEL, {14'h0, st, sp, 3'h0, sd, 3'h0, sm});
  endtask

  function automatic logic [4:0] clamp_del(input logic [4:0] sm, input logic [4:0] sd);
    return (sm > 4 && sd < sm - 4) ? sm - 5'h4 : sd;
  endfunction

  function automatic logic [2:0] exp_mode(input logic [4:0] sm, sd, input logic sp);
    if (sm == 0) return `HDMC_M_XY;
    if (sp && sm == 25) return `HDMC_M_TRIM;
    if (sd + 3 == sm - 1) return sp ? `HDMC_M_INTEN : `HDMC_M_MAIN;
    return sp ? `HDMC_M_ALT : `HDMC_M_DEL;
  endfunction

  // one sweep while counting zone cycles
  task zones(input int trig, input int er, input int ed);
    {ni, nr, nd} = 0;
    fork
      u_pm.sweep(40, trig);
      repeat (46) begin
        @(posedge pclk);
        ni += intensify;
        nr += zone_ref;
        nd += zone_delta;
      end
    join
    chk(nr, er);
    chk(nd, ed);
    chk(ni, er + ed);
  endtask

  // ******
  // main sequence
  // ******
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, trace_ord} = 0;
    trace_count = 3'h1;
    corners = {5'h19, 5'h15, 1'b1, 5'h0, 5'h0, 1'b0, 5'h0A, 5'h06, 1'b0, 5'h16, 5'h12, 1'b1};
    void'($urandom(32'hf909));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `HDMC_PANEL, 0);
    chk(rd, 32'h0000_0001);
    apb(0, 12'h01C, 0);
    chk({err, rd}, 33'h1_0000_0000);
    for (int i = 0; i < 40; i++) begin
      m = $urandom_range(25, 0);
      d = $urandom_range(21, 0);
      p = $urandom_range(1, 0);
      if (i < 4) {m, d, p} = corners[(3 - i) * 11 +: 11];
      set_panel(m, d, p, 0);
      apb(0, `HDMC_PANEL, 0);
      d = clamp_del(m, d);
      chk(rd, {15'h0, p, 3'h0, d, 3'h0, m});
      u_pm.sweep(8, 0);
      @(posedge pclk);
      e = exp_mode(m, d, p);
      chk(display_mode, e);
      chk({xy_mode, skew_trim}, {m == 0, e == `HDMC_M_TRIM});
      if (e == `HDMC_M_INTEN) chk(delayed_run_step, m > 19 ? 24 : m + 5);
      if (e == `HDMC_M_ALT || e == `HDMC_M_DEL) chk(delayed_run_step, d + 3);
      if (e < `HDMC_M_XY) chk(var_on_delayed, e != `HDMC_M_MAIN);
    end
    set_panel(10, 6, 1, 0);
    apb(1, `HDMC_REF_DLY, 32'h5);
    apb(1, `HDMC_DELTA_DLY, 32'h14);
    apb(1, `HDMC_ZONE_LEN, 32'h4);
    apb(1, `HDMC_MEAS, 0);
    zones(0, 4, 0);
    apb(1, `HDMC_MEAS, 32'h2);
    zones(0, 4, 4);
    trace_count <= 3'h2;
    trace_ord <= 3'h1;
    zones(0, 0, 4);
    trace_ord <= 3'h0;
    zones(0, 4, 0);
    apb(1, `HDMC_PANEL, 32'h0005_060A);
    zones(0, 4, 4);
    trace_count <= 3'h1;
    set_panel(10, 6, 1, 1);
    zones(0, 0, 0);
    zones(10, 4, 0);
    set_panel(10, 6, 0, 0);
    apb(1, `HDMC_MEAS, 32'h1);
    set_panel(10, 6, 1, 0);
    hit = 0;
    repeat (6) begin
      @(posedge pclk);
      hit = hit | dv_cancel;
    end
    apb(0, `HDMC_MEAS, 0);
    chk({hit[0], rd}, 33'h1_0000_0000);
    apb(1, `HDMC_MEAS, 32'h1);
    apb(0, `HDMC_MEAS, 0);
    chk(rd, 32'h0000_0100);
    set_panel(10, 6, 0, 0);
    apb(0, `HDMC_MEAS, 0);
    chk(rd, 0);
    u_pm.turn(1, 20);
    apb(0, `HDMC_STATUS, 0);
    chk(rd[16:8], 9'h129);
    u_pm.turn(0, 1);
    apb(0, `HDMC_STATUS, 0);
    chk(rd[16:8], 9'h028);
    apb(0, `HDMC_SCALE, 0);
    chk(rd, 32'h0000_19A2);
    finish_test();
  end
endmodule

bind hdmc_top hdmc_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .display_mode(display_mode), .xy_mode(xy_mode), .skew_trim(skew_trim),
  .show_main(show_main), .show_delayed(show_delayed), .delayed_run_step(delayed_run_step),
  .var_on_delayed(var_on_delayed), .intensify(intensify), .zone_ref(zone_ref),
  .zone_delta(zone_delta), .dv_cancel(dv_cancel));
